// ===== hw/rda_pkg.sv
package rda_pkg;
  // register index; the byte address is four times the index
  localparam logic [3:0] IDX_ALM_MIN = 4'hb;
  localparam logic [3:0] IDX_ALM_HOUR = 4'hc;
  localparam logic [3:0] IDX_CTRL_ONE = 4'he;
  localparam logic [3:0] IDX_CTRL_TWO = 4'hf;
  localparam int ADDR_W = 6;

  localparam logic [7:0] ALM_MIN_MASK = 8'h7f;
  localparam logic [7:0] ALM_HOUR_MASK = 8'h3f;
  localparam logic [7:0] ALM_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;

  // control_one field positions
  localparam int CO_WEEKLY_EN = 7;
  localparam int CO_DAILY_EN = 6;
  localparam int CO_HOUR24 = 5;
  localparam int CO_GATE_TWO = 4;
  localparam int CO_TEST = 3;
  localparam int CO_SEL_HI = 2;

  // control_two_status field positions
  localparam int CT_THR = 7;
  localparam int CT_DROP = 6;
  localparam int CT_OSC = 5;
  localparam int CT_PON = 4;
  localparam int CT_GATE_ONE = 3;
  localparam int CT_PER = 2;
  localparam int CT_WEEKLY = 1;
  localparam int CT_DAILY = 0;

  localparam logic CT_BIT_RST = 1'b0;
  localparam logic PON_RST = 1'b1;
  localparam logic OSC_RST = 1'b0;

  // periodic select codes
  localparam logic [2:0] PER_OFF = 3'h0;
  localparam logic [2:0] PER_LOW = 3'h1;
  localparam logic [2:0] PER_2HZ = 3'h2;
  localparam logic [2:0] PER_1HZ = 3'h3;
  localparam logic [2:0] PER_SEC = 3'h4;
  localparam logic [2:0] PER_MIN = 3'h5;
  localparam logic [2:0] PER_HOUR = 3'h6;
  localparam logic [2:0] PER_MONTH = 3'h7;

  localparam int CLK_HZ = 25000000;
  localparam int HALF_2HZ_MS = 250;
  localparam int HALF_2HZ_CYC = CLK_HZ / 1000 * HALF_2HZ_MS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SYNC_W = 4;

  typedef enum logic [1:0] {
    RDA_WR_IDLE = 2'b01,
    RDA_WR_RESP = 2'b10
  } rda_wr_state_e;
endpackage : rda_pkg

// ===== hw/rda_sync3.sv
`timescale 1ns/100ps
module rda_sync3 (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [rda_pkg::SYNC_W-1:0] pin_in,
  output logic [rda_pkg::SYNC_W-1:0] pin_q
);
  genvar i;
  generate
    for (i = 0; i < rda_pkg::SYNC_W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic q;
      assign pin_q[i] = q;
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q <= 1'b0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          // a change counts only once two stages agree
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : rda_sync3

// ===== hw/rda_half_wave.sv
`timescale 1ns/100ps
module rda_half_wave #(
  parameter int HALF_CYC = rda_pkg::HALF_2HZ_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic wave_2hz,
  output logic wave_1hz
);
  logic [31:0] cnt;
  logic tick;

  assign tick = (cnt == 32'(HALF_CYC - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 32'h0;
    end else if (tick) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // 1 hz derives from the 2 hz edge so both stay phase locked
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wave_2hz <= 1'b1;
      wave_1hz <= 1'b1;
    end else if (tick) begin
      wave_2hz <= ~wave_2hz;
      if (wave_2hz) begin
        wave_1hz <= ~wave_1hz;
      end
    end
  end
endmodule : rda_half_wave

// ===== hw/rda_top.sv
// Functional notes
// R01: minute and hour alarm registers, compared when enabled
// R02: match drives daily irq low, sets flag
// R03: match counts only when counters advance
// R04: hour bit 5 is twenties or pm
// R05: control_one layout, all zero at reset
// R06: weekly enable gates weekly compare and irq
// R07: daily enable gates daily compare and irq
// R08: hour format bit, zero is 12-hour
// R09: software sets hour format before time
// R10: both gate bits one stop clock output
// R11: power-on reset clears both gate bits
// R12: software always writes test bit zero
// R13: codes 0-3: off, low, 2hz, 1hz
// R14: codes 4-7: second, minute, hour, month events
// R15: control_two_status layout and reset values
// R16: threshold bit picks 2.1 V or 1.3 V
// R17: drop sets power-drop flag until cleared
// R18: writing zero clears drop flag, one ignored
// R19: writing one arms stop detect, zero ignored
// R20: detected stop clears flag until rearmed
// R21: power-on sets flag, clears controls, irqs off
// R22: daily flag clear releases irq if periodic off
// R23: fixed-zero alarm bits read zero
`timescale 1ns/100ps
module rda_top #(
  parameter int HALF_CYC = rda_pkg::HALF_2HZ_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [rda_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rda_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] cur_minute,
  input wire logic [7:0] cur_hour,
  input wire logic sec_tick,
  input wire logic min_zero_tick,
  input wire logic hour_zero_tick,
  input wire logic month_tick,
  input wire logic weekly_match,
  input wire logic clock_output_enable_in,
  input wire logic drop_below_hi,
  input wire logic drop_below_lo,
  input wire logic osc_stop_seen,
  output logic daily_irq_n_out,
  output logic daily_irq_n_oe,
  output logic weekly_irq_n_out,
  output logic weekly_irq_n_oe,
  output logic clock_output_on,
  output logic hour_24_mode,
  output logic weekly_compare_on,
  output logic drop_threshold_select_out
);
  rda_pkg::rda_wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [3:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_fire;
  logic wr_hit;
  logic wr_min;
  logic wr_hour;
  logic wr_one;
  logic wr_two;
  logic [3:0] rd_idx;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [7:0] daily_alarm_minute;
  logic [7:0] daily_alarm_hour;
  logic [7:0] control_one;
  logic drop_threshold_select;
  logic power_drop_flag;
  logic osc_stop_flag_n;
  logic power_on_flag;
  logic clkout_gate_one_n;
  logic periodic_event_flag;
  logic weekly_alarm_flag;
  logic daily_alarm_flag;
  logic periodic_on;
  logic periodic_level;
  logic level_event;
  logic [2:0] periodic_sel;
  logic [7:0] prev_minute;
  logic [7:0] prev_hour;
  logic time_moved;
  logic daily_match;
  logic wave_2hz;
  logic wave_1hz;
  logic [rda_pkg::SYNC_W-1:0] pin_q;
  logic drop_now;
  rda_sync3 u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({osc_stop_seen, drop_below_lo, drop_below_hi, clock_output_enable_in}),
    .pin_q(pin_q)
  );
  rda_half_wave #(
    .HALF_CYC(HALF_CYC)
  ) u_wave (
    .core_clk(core_clk),
    .nrst(nrst),
    .wave_2hz(wave_2hz),
    .wave_1hz(wave_1hz)
  );
  // write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held && (wr_state == rda_pkg::RDA_WR_IDLE);
  assign s_axi_wready = !w_held && (wr_state == rda_pkg::RDA_WR_IDLE);
  assign wr_fire = aw_held && w_held && (wr_state == rda_pkg::RDA_WR_IDLE);
  assign wr_hit = (wr_idx == rda_pkg::IDX_ALM_MIN) || (wr_idx == rda_pkg::IDX_ALM_HOUR)
    || (wr_idx == rda_pkg::IDX_CTRL_ONE) || (wr_idx == rda_pkg::IDX_CTRL_TWO);
  assign wr_min = wr_fire && wr_lane && (wr_idx == rda_pkg::IDX_ALM_MIN);
  assign wr_hour = wr_fire && wr_lane && (wr_idx == rda_pkg::IDX_ALM_HOUR);
  assign wr_one = wr_fire && wr_lane && (wr_idx == rda_pkg::IDX_CTRL_ONE);
  assign wr_two = wr_fire && wr_lane && (wr_idx == rda_pkg::IDX_CTRL_TWO);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      wr_idx <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_idx <= s_axi_awaddr[5:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      w_held <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_byte <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state <= rda_pkg::RDA_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rda_pkg::RESP_OKAY;
    end else begin
      case (wr_state)
        rda_pkg::RDA_WR_IDLE: begin
          if (wr_fire) begin
            wr_state <= rda_pkg::RDA_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? rda_pkg::RESP_OKAY : rda_pkg::RESP_SLVERR;
          end
        end
        rda_pkg::RDA_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= rda_pkg::RDA_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= rda_pkg::RDA_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end
  // read channel: one cycle to data, held until rready
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[5:2];
  assign rd_hit = (rd_idx == rda_pkg::IDX_ALM_MIN) || (rd_idx == rda_pkg::IDX_ALM_HOUR)
    || (rd_idx == rda_pkg::IDX_CTRL_ONE) || (rd_idx == rda_pkg::IDX_CTRL_TWO);
  always_comb begin
    case (rd_idx)
      rda_pkg::IDX_ALM_MIN: rd_byte = daily_alarm_minute;
      rda_pkg::IDX_ALM_HOUR: rd_byte = daily_alarm_hour;
      rda_pkg::IDX_CTRL_ONE: rd_byte = control_one;
      rda_pkg::IDX_CTRL_TWO: rd_byte = {drop_threshold_select, power_drop_flag, osc_stop_flag_n, power_on_flag,
        clkout_gate_one_n, periodic_event_flag, weekly_alarm_flag, daily_alarm_flag}; // R15
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rda_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rd_byte};
      s_axi_rresp <= rd_hit ? rda_pkg::RESP_OKAY : rda_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // alarm registers; fixed-zero bits never store
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      daily_alarm_minute <= rda_pkg::ALM_RST;
      daily_alarm_hour <= rda_pkg::ALM_RST;
    end else begin
      if (wr_min) begin
        daily_alarm_minute <= wr_byte & rda_pkg::ALM_MIN_MASK; // R01 R23
      end
      if (wr_hour) begin
        daily_alarm_hour <= wr_byte & rda_pkg::ALM_HOUR_MASK; // R01 R04 R23
      end
    end
  end
  // test bit is stored as written; software keeps it zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      control_one <= rda_pkg::CTRL_ONE_RST; // R05 R11 R21
    end else if (wr_one) begin
      control_one <= wr_byte; // R05 R12
    end
  end

  assign periodic_sel = control_one[rda_pkg::CO_SEL_HI:0];
  assign hour_24_mode = control_one[rda_pkg::CO_HOUR24]; // R08 R09
  assign weekly_compare_on = control_one[rda_pkg::CO_WEEKLY_EN]; // R06
  assign drop_threshold_select_out = drop_threshold_select; // R16
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drop_threshold_select <= rda_pkg::CT_BIT_RST;
      clkout_gate_one_n <= rda_pkg::CT_BIT_RST; // R11 R21
    end else if (wr_two) begin
      drop_threshold_select <= wr_byte[rda_pkg::CT_THR];
      clkout_gate_one_n <= wr_byte[rda_pkg::CT_GATE_ONE];
    end
  end

  // power-on flag: only a reset sets it, software may only clear it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_on_flag <= rda_pkg::PON_RST; // R21
    end else if (wr_two && !wr_byte[rda_pkg::CT_PON]) begin
      power_on_flag <= 1'b0;
    end
  end
  assign drop_now = drop_threshold_select ? pin_q[2] : pin_q[1]; // R16
  // detection wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_drop_flag <= rda_pkg::CT_BIT_RST;
    end else if (drop_now) begin
      power_drop_flag <= 1'b1; // R17
    end else if (wr_two && !wr_byte[rda_pkg::CT_DROP]) begin
      power_drop_flag <= 1'b0; // R18
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_stop_flag_n <= rda_pkg::OSC_RST;
    end else if (pin_q[3]) begin
      osc_stop_flag_n <= 1'b0; // R20
    end else if (wr_two && wr_byte[rda_pkg::CT_OSC]) begin
      osc_stop_flag_n <= 1'b1; // R19
    end
  end

  // counters moving is what arms a match, so loading the shown time is silent
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_minute <= 8'h00;
      prev_hour <= 8'h00;
    end else begin
      prev_minute <= cur_minute;
      prev_hour <= cur_hour;
    end
  end

  assign time_moved = (cur_minute != prev_minute) || (cur_hour != prev_hour); // R03
  assign daily_match = time_moved && control_one[rda_pkg::CO_DAILY_EN]
    && ((cur_minute & rda_pkg::ALM_MIN_MASK) == daily_alarm_minute)
    && ((cur_hour & rda_pkg::ALM_HOUR_MASK) == daily_alarm_hour); // R01 R03 R04 R07

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      daily_alarm_flag <= rda_pkg::CT_BIT_RST;
    end else if (!control_one[rda_pkg::CO_DAILY_EN]) begin
      daily_alarm_flag <= 1'b0; // R07
    end else if (daily_match) begin
      daily_alarm_flag <= 1'b1; // R02
    end else if (wr_two && !wr_byte[rda_pkg::CT_DAILY] && !periodic_on) begin
      daily_alarm_flag <= 1'b0; // R22
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      weekly_alarm_flag <= rda_pkg::CT_BIT_RST;
    end else if (!control_one[rda_pkg::CO_WEEKLY_EN]) begin
      weekly_alarm_flag <= 1'b0; // R06
    end else if (weekly_match) begin
      weekly_alarm_flag <= 1'b1; // R06
    end else if (wr_two && !wr_byte[rda_pkg::CT_WEEKLY]) begin
      weekly_alarm_flag <= 1'b0;
    end
  end

  // level-mode periodic events
  always_comb begin
    case (periodic_sel)
      rda_pkg::PER_SEC: level_event = sec_tick; // R14
      rda_pkg::PER_MIN: level_event = min_zero_tick; // R14
      rda_pkg::PER_HOUR: level_event = hour_zero_tick; // R14
      rda_pkg::PER_MONTH: level_event = month_tick; // R14
      default: level_event = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_level <= 1'b0;
    end else if (!periodic_sel[2]) begin
      periodic_level <= 1'b0;
    end else if (level_event) begin
      periodic_level <= 1'b1; // R14
    end else if (wr_two && !wr_byte[rda_pkg::CT_PER]) begin
      periodic_level <= 1'b0;
    end
  end

  // pulse modes are low during the second half of each period
  always_comb begin
    case (periodic_sel)
      rda_pkg::PER_OFF: periodic_on = 1'b0; // R13
      rda_pkg::PER_LOW: periodic_on = 1'b1; // R13
      rda_pkg::PER_2HZ: periodic_on = !wave_2hz; // R13
      rda_pkg::PER_1HZ: periodic_on = !wave_1hz; // R13
      default: periodic_on = periodic_level;
    endcase
  end
  assign periodic_event_flag = periodic_on;
  // open-drain pins only ever pull low
  assign daily_irq_n_out = 1'b0;
  assign weekly_irq_n_out = 1'b0;
  assign daily_irq_n_oe = daily_alarm_flag || periodic_on; // R02 R21 R22
  assign weekly_irq_n_oe = weekly_alarm_flag; // R06 R21

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clock_output_on <= 1'b0;
    end else begin
      clock_output_on <= pin_q[0] && !(clkout_gate_one_n && control_one[rda_pkg::CO_GATE_TWO]); // R10
    end
  end
endmodule : rda_top

// ===== dv/rda_top_monitor.sv
`timescale 1ns/100ps
module rda_top_monitor (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [rda_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [rda_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic weekly_match,
  input wire logic clock_output_enable_in,
  input wire logic daily_irq_n_oe,
  input wire logic weekly_irq_n_oe,
  input wire logic clock_output_on,
  input wire logic hour_24_mode,
  input wire logic weekly_compare_on,
  input wire logic drop_threshold_select_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // targets are latched since the master drops them before the answer
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_idx <= 4'h0;
      rd_idx <= 4'h0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wr_idx <= s_axi_awaddr[5:2];
      if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[5:2];
      if (s_axi_wvalid && s_axi_wready) wr_byte <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) wr_lane <= s_axi_wstrb[0];
    end
  end
  property p_reset_out;
    !$past(nrst) |-> !daily_irq_n_oe && !weekly_irq_n_oe && !hour_24_mode && !weekly_compare_on
      && !drop_threshold_select_out && !clock_output_on;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
  property p_ctrl_one_wr;
    $rose(s_axi_bvalid) && wr_lane && wr_idx == rda_pkg::IDX_CTRL_ONE
      |-> weekly_compare_on == wr_byte[rda_pkg::CO_WEEKLY_EN];
  endproperty
  a_ctrl_one_wr: assert property (p_ctrl_one_wr) else $error("weekly enable not stored");
  property p_hour_fmt;
    $rose(s_axi_bvalid) && wr_lane && wr_idx == rda_pkg::IDX_CTRL_ONE
      |-> hour_24_mode == wr_byte[rda_pkg::CO_HOUR24];
  endproperty
  a_hour_fmt: assert property (p_hour_fmt) else $error("hour format not stored");
  property p_thr_wr;
    $rose(s_axi_bvalid) && wr_lane && wr_idx == rda_pkg::IDX_CTRL_TWO
      |-> drop_threshold_select_out == wr_byte[rda_pkg::CT_THR];
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("threshold select not stored");
  property p_weekly;
    weekly_match && !weekly_irq_n_oe |=> weekly_irq_n_oe == $past(weekly_compare_on);
  endproperty
  a_weekly: assert property (p_weekly) else $error("weekly irq ignores enable");
  property p_clkout_off;
    !clock_output_enable_in [*5] |=> !clock_output_on;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock output runs while disabled");
  property p_alarm_zero;
    $rose(s_axi_rvalid) && (rd_idx == rda_pkg::IDX_ALM_MIN || rd_idx == rda_pkg::IDX_ALM_HOUR)
      |-> (s_axi_rdata & ~{24'h0, (rd_idx == rda_pkg::IDX_ALM_MIN) ? rda_pkg::ALM_MIN_MASK
      : rda_pkg::ALM_HOUR_MASK}) == 32'h0;
  endproperty
  a_alarm_zero: assert property (p_alarm_zero) else $error("fixed zero alarm bit set");
  property p_status_oe;
    $rose(s_axi_rvalid) && rd_idx == rda_pkg::IDX_CTRL_TWO
      |-> (s_axi_rdata[rda_pkg::CT_DAILY] || s_axi_rdata[rda_pkg::CT_PER]) == $past(daily_irq_n_oe)
      && s_axi_rdata[rda_pkg::CT_WEEKLY] == $past(weekly_irq_n_oe);
  endproperty
  a_status_oe: assert property (p_status_oe) else $error("status flags disagree with irqs");
endmodule : rda_top_monitor

bind rda_top rda_top_monitor rda_top_monitor_inst (
  .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .weekly_match, .clock_output_enable_in, .daily_irq_n_oe,
  .weekly_irq_n_oe, .clock_output_on, .hour_24_mode, .weekly_compare_on, .drop_threshold_select_out
);

// ===== dv/tb_rda_top.sv
`timescale 1ns/100ps
module tb_rda_top;
  localparam logic [5:0] A_MIN = {rda_pkg::IDX_ALM_MIN, 2'b00};
  localparam logic [5:0] A_HOUR = {rda_pkg::IDX_ALM_HOUR, 2'b00};
  localparam logic [5:0] A_C1 = {rda_pkg::IDX_CTRL_ONE, 2'b00};
  localparam logic [5:0] A_C2 = {rda_pkg::IDX_CTRL_TWO, 2'b00};
  // short wave half period keeps the pulse modes within a few dozen cycles
  localparam int HALF = 8;
  logic core_clk = 1'b0;
  logic nrst, clock_output_enable_in;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] cur_minute, cur_hour;
  logic [4:0] pt;
  logic [2:0] ap;
  logic sec_tick, min_zero_tick, hour_zero_tick, month_tick, weekly_match;
  logic drop_below_hi, drop_below_lo, osc_stop_seen;
  logic daily_irq_n_out, daily_irq_n_oe, weekly_irq_n_out, weekly_irq_n_oe, clock_output_on;
  logic hour_24_mode, weekly_compare_on, drop_threshold_select_out;
  int fails = 0;
  int cmp_count = 0;
  int hi, ri;
  int exp_hi[4] = '{0, 8 * HALF, 4 * HALF, 4 * HALF};
  int exp_ri[4] = '{0, 0, 4, 2};
  assign {weekly_match, month_tick, hour_zero_tick, min_zero_tick, sec_tick} = pt;
  assign {osc_stop_seen, drop_below_lo, drop_below_hi} = ap;
  always #20 core_clk = ~core_clk;
  rda_top #(.HALF_CYC(HALF)) rda_top_inst (
    .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cur_minute, .cur_hour, .sec_tick, .min_zero_tick, .hour_zero_tick, .month_tick, .weekly_match,
    .clock_output_enable_in, .drop_below_hi, .drop_below_lo, .osc_stop_seen, .daily_irq_n_out,
    .daily_irq_n_oe, .weekly_irq_n_out, .weekly_irq_n_oe, .clock_output_on, .hour_24_mode,
    .weekly_compare_on, .drop_threshold_select_out
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rchk
  task automatic pulse(input logic [4:0] v);
    @(posedge core_clk);
    pt <= v;
    @(posedge core_clk);
    pt <= 5'h0;
    @(posedge core_clk);
  endtask : pulse
  // pins pass a synchroniser, so each level is held long enough to be seen
  task automatic apin(input logic [2:0] v);
    @(posedge core_clk);
    ap <= v;
    cyc(6);
    ap <= 3'h0;
    cyc(6);
  endtask : apin
  task automatic setmin(input logic [7:0] v);
    @(posedge core_clk);
    cur_minute <= v;
    cyc(3);
  endtask : setmin
  task automatic wave();
    logic prev;
    prev = daily_irq_n_oe;
    hi = 0;
    ri = 0;
    repeat (8 * HALF) begin
      @(posedge core_clk);
      hi += int'(daily_irq_n_oe);
      ri += int'(daily_irq_n_oe && !prev);
      prev = daily_irq_n_oe;
    end
  endtask : wave
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    cyc(20000);
    fails++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    clock_output_enable_in = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    cur_minute = 8'h29;
    cur_hour = 8'h21;
    pt = 5'h0;
    ap = 3'h0;
    cyc(10);
    nrst <= 1'b1;
    rchk(A_C1, 32'h00);
    rchk(A_C2, 32'h10);
    wr(A_MIN, 8'hff);
    chk(rsp, rda_pkg::RESP_OKAY);
    rchk(A_MIN, 32'h7f);
    wr(A_HOUR, 8'hff);
    rchk(A_HOUR, 32'h3f);
    wr(6'h00, 8'h55);
    chk(rsp, rda_pkg::RESP_SLVERR);
    rchk(6'h00, 32'h0);
    chk(rsp, rda_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(A_MIN, 8'h30);
    wr(A_HOUR, 8'h21);
    wr(A_C1, 8'h20);
    setmin(8'h30);
    chk(daily_irq_n_oe, 0);
    wr(A_C1, 8'h60);
    chk(hour_24_mode, 1);
    wr(A_MIN, 8'h30);
    cyc(3);
    chk(daily_irq_n_oe, 0);
    setmin(8'h31);
    setmin(8'h30);
    chk(daily_irq_n_oe, 1);
    chk(daily_irq_n_out, 0);
    rchk(A_C2, 32'h11);
    wr(A_C1, 8'h61);
    wr(A_C2, 8'h20);
    rchk(A_C2, 32'h25);
    wr(A_C1, 8'h60);
    wr(A_C2, 8'h20);
    rchk(A_C2, 32'h20);
    chk(daily_irq_n_oe, 0);
    $display("test daily alarm done");
    for (int c = 0; c < 4; c++) begin
      wr(A_C1, 8'(c));
      wave();
      chk(hi, exp_hi[c]);
      chk(ri, exp_ri[c]);
    end
    for (int c = 4; c < 8; c++) begin
      wr(A_C1, 8'(c));
      pulse(5'h0f & ~(5'h1 << (c - 4)));
      chk(daily_irq_n_oe, 0);
      pulse(5'h1 << (c - 4));
      chk(daily_irq_n_oe, 1);
      wr(A_C2, 8'h73);
      chk(daily_irq_n_oe, 0);
    end
    $display("test periodic done");
    wr(A_C1, 8'h00);
    pulse(5'h10);
    chk(weekly_irq_n_oe, 0);
    wr(A_C1, 8'h80);
    chk(weekly_compare_on, 1);
    pulse(5'h10);
    chk(weekly_irq_n_oe, 1);
    chk(weekly_irq_n_out, 0);
    rchk(A_C2, 32'h22);
    wr(A_C2, 8'h75);
    chk(weekly_irq_n_oe, 0);
    wr(A_C1, 8'h00);
    $display("test weekly done");
    apin(3'b001);
    rchk(A_C2, 32'h60);
    wr(A_C2, 8'h77);
    rchk(A_C2, 32'h60);
    wr(A_C2, 8'h37);
    rchk(A_C2, 32'h20);
    wr(A_C2, 8'hb7);
    chk(drop_threshold_select_out, 1);
    apin(3'b001);
    rchk(A_C2, 32'ha0);
    apin(3'b010);
    rchk(A_C2, 32'he0);
    wr(A_C2, 8'h37);
    rchk(A_C2, 32'h20);
    wr(A_C2, 8'h57);
    rchk(A_C2, 32'h20);
    apin(3'b100);
    rchk(A_C2, 32'h00);
    wr(A_C2, 8'h57);
    rchk(A_C2, 32'h00);
    wr(A_C2, 8'h77);
    rchk(A_C2, 32'h20);
    $display("test detection done");
    clock_output_enable_in <= 1'b1;
    cyc(6);
    chk(clock_output_on, 1);
    wr(A_C1, 8'h10);
    cyc(2);
    chk(clock_output_on, 1);
    wr(A_C2, 8'h7f);
    cyc(2);
    chk(clock_output_on, 0);
    rchk(A_C2, 32'h28);
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    cyc(6);
    chk(clock_output_on, 1);
    rchk(A_C1, 32'h00);
    rchk(A_C2, 32'h10);
    clock_output_enable_in <= 1'b0;
    cyc(6);
    chk(clock_output_on, 0);
    $display("test clock output done");
    finish_test();
  end
endmodule : tb_rda_top
